// file: logic/periph_enable_decode.sv
// Peripheral enable register, its emulation mirror and address steering.
// Assumes register strobes and CPU address are synchronous to ref_clk.

`timescale 1ns/10ps

module periph_enable_decode (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_b,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [15:0]                  reg_addr,
  input  wire logic [15:0]                  reg_wdata,
  output logic      [15:0]                  reg_rdata_q,
  output logic                              reg_rvalid_q,
  input  wire logic                         global_bus_enable,
  input  wire logic                         internal_rom_enable,
  input  wire logic                         emul_mode,
  input  wire logic                         powerdown_mode,
  input  wire logic                         osc_powerdown_select,
  input  wire logic                         acc_valid,
  input  wire logic [23:0]                  acc_addr,
  output periph_enable_pkg::target_t        route_tgt_q,
  output logic                              route_valid_q,
  output logic      [11:0]                  periph_enable_q,
  output logic      [11:0]                  gpio_release_q,
  output logic      [15:0]                  mirror_q,
  output logic                              osc_off_q
);

  // ------------------------------------------------------------------
  // Enable register
  // ------------------------------------------------------------------
  logic [15:0] control_q;
  logic        ctl_hit;
  logic        mir_hit;

  assign ctl_hit = reg_addr == periph_enable_pkg::ADDR_CONTROL;
  assign mir_hit = reg_addr == periph_enable_pkg::ADDR_MIRROR;

  // Reserved bits never stored, so they always read zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      control_q <= periph_enable_pkg::CONTROL_RESET;
    end else if (reg_wr && ctl_hit && !global_bus_enable) begin
      control_q <= reg_wdata & periph_enable_pkg::CONTROL_MASK;
    end
  end

  // ------------------------------------------------------------------
  // Write-only mirror
  // ------------------------------------------------------------------
  // No lock here: emulation setup writes it after the global enable
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mirror_q <= 16'h0000;
    end else if (reg_wr && mir_hit) begin
      mirror_q <= reg_wdata & periph_enable_pkg::MIRROR_MASK;
    end
  end

  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q  <= 16'h0000;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      // Mirror and unmapped addresses read as zero
      reg_rdata_q  <= (reg_rd && ctl_hit) ? control_q : 16'h0000;
    end
  end

  // ------------------------------------------------------------------
  // Effective enables
  // ------------------------------------------------------------------
  logic [11:0] en;

  // Outside emulation, on-chip modules only appear once globally enabled
  assign en = emul_mode ? 12'hFFF
            : (global_bus_enable ? control_q[11:0] : 12'h000);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      periph_enable_q <= 12'h000;
    end else begin
      periph_enable_q <= en;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < periph_enable_pkg::EN_W; gi++) begin : g_pin
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          gpio_release_q[gi] <= 1'b1;
        end else begin
          gpio_release_q[gi] <= !en[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Address steering
  // ------------------------------------------------------------------
  function automatic logic in_rng(input logic [23:0] a,
                                  input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  periph_enable_pkg::target_t tgt_d;
  logic                       win_off;
  logic                       xp_hit;
  logic [23:0]                a;

  assign a       = acc_addr;
  assign win_off = (en & periph_enable_pkg::WINDOW_PERIPH_MASK) == 12'h000;

  always_comb begin
    xp_hit =
      (en[periph_enable_pkg::BIT_SSC] && in_rng(a, periph_enable_pkg::SSC_LO,
        periph_enable_pkg::SSC_LO + periph_enable_pkg::SUB_256)) ||
      (en[periph_enable_pkg::BIT_ASC] && in_rng(a, periph_enable_pkg::ASC_LO,
        periph_enable_pkg::ASC_LO + periph_enable_pkg::SUB_256)) ||
      (en[periph_enable_pkg::BIT_I2C] && in_rng(a, periph_enable_pkg::I2C_LO,
        periph_enable_pkg::I2C_LO + periph_enable_pkg::SUB_256)) ||
      (en[periph_enable_pkg::BIT_MISC] && in_rng(a, periph_enable_pkg::MISC_LO,
        periph_enable_pkg::MISC_LO + periph_enable_pkg::SUB_128)) ||
      (en[periph_enable_pkg::BIT_PORT] && in_rng(a, periph_enable_pkg::PORT_LO,
        periph_enable_pkg::PORT_LO + periph_enable_pkg::SUB_128)) ||
      (en[periph_enable_pkg::BIT_PWM] && in_rng(a, periph_enable_pkg::PWM_LO,
        periph_enable_pkg::PWM_LO + periph_enable_pkg::SUB_256));
  end

  always_comb begin
    tgt_d = periph_enable_pkg::TGT_OTHER;
    if (emul_mode) begin
      tgt_d = periph_enable_pkg::TGT_EMUL;
    end else if (in_rng(a, periph_enable_pkg::SEG8_LO, periph_enable_pkg::SEG8_HI)) begin
      if (internal_rom_enable) begin
        tgt_d = periph_enable_pkg::TGT_IFLASH;
      end else if (!global_bus_enable) begin
        tgt_d = periph_enable_pkg::TGT_EXTERNAL;
      end else if (!control_q[periph_enable_pkg::BIT_RAM_L] &&
                   !control_q[periph_enable_pkg::BIT_FLASH]) begin
        tgt_d = periph_enable_pkg::TGT_EXTERNAL;
      end else begin
        tgt_d = periph_enable_pkg::TGT_RESERVED;
      end
    end else if (in_rng(a, periph_enable_pkg::FLASH_LO, periph_enable_pkg::FLASH_HI)) begin
      if (en[periph_enable_pkg::BIT_FLASH]) begin
        tgt_d = periph_enable_pkg::TGT_XFLASH;
      end else if (!en[periph_enable_pkg::BIT_RAM_L]) begin
        tgt_d = periph_enable_pkg::TGT_EXTERNAL;
      end else begin
        tgt_d = periph_enable_pkg::TGT_UNCLAIM;
      end
    end else if (in_rng(a, periph_enable_pkg::RAM_L_LO, periph_enable_pkg::RAM_L_HI)) begin
      if (en[periph_enable_pkg::BIT_RAM_L]) begin
        tgt_d = periph_enable_pkg::TGT_RAM_L;
      end else if (!en[periph_enable_pkg::BIT_FLASH]) begin
        tgt_d = periph_enable_pkg::TGT_EXTERNAL;
      end else begin
        tgt_d = periph_enable_pkg::TGT_UNCLAIM;
      end
    end else if (in_rng(a, periph_enable_pkg::RAM_S_LO, periph_enable_pkg::RAM_S_HI)) begin
      tgt_d = en[periph_enable_pkg::BIT_RAM_S] ? periph_enable_pkg::TGT_RAM_S
                                               : periph_enable_pkg::TGT_EXTERNAL;
    end else if (in_rng(a, periph_enable_pkg::WIN_LO, periph_enable_pkg::WIN_HI)) begin
      // Calendar wins its slice over the wider CAN window
      if (en[periph_enable_pkg::BIT_RTC] &&
          in_rng(a, periph_enable_pkg::RTC_LO, periph_enable_pkg::RTC_HI)) begin
        tgt_d = periph_enable_pkg::TGT_RTC;
      end else if (xp_hit) begin
        tgt_d = periph_enable_pkg::TGT_XPERIPH;
      end else if ((en[periph_enable_pkg::BIT_CAN1] || en[periph_enable_pkg::BIT_CAN2]) &&
                   in_rng(a, periph_enable_pkg::CAN_LO, periph_enable_pkg::WIN_HI)) begin
        tgt_d = periph_enable_pkg::TGT_CAN;
      end else if (win_off) begin
        // Bus timing comes from the matching address window downstream
        tgt_d = periph_enable_pkg::TGT_EXTERNAL;
      end else begin
        tgt_d = periph_enable_pkg::TGT_UNCLAIM;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      route_tgt_q   <= periph_enable_pkg::TGT_OTHER;
      route_valid_q <= 1'b0;
    end else begin
      route_tgt_q   <= tgt_d;
      route_valid_q <= acc_valid;
    end
  end

  // ------------------------------------------------------------------
  // Oscillator power-down
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_off_q <= 1'b0;
    end else begin
      osc_off_q <= powerdown_mode &&
                   (!en[periph_enable_pkg::BIT_RTC] || osc_powerdown_select);
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_RESET_VALUE: assert property ($rose(rst_b) |-> control_q == 16'h0005)
    else $error("enable register reset value wrong");
  AST_LOCKED: assert property (global_bus_enable |=> $stable(control_q))
    else $error("enable register changed while locked");
  AST_CTRL_WRITE: assert property (reg_wr && ctl_hit && !global_bus_enable |=>
                                   control_q == ($past(reg_wdata) & 16'h0FFF))
    else $error("enable register write lost");
  AST_MIRROR_WRITE: assert property (reg_wr && mir_hit |=>
                                     mirror_q[15:12] == 4'h0 &&
                                     mirror_q[11:0] == $past(reg_wdata[11:0]))
    else $error("mirror did not capture write");
  AST_MIRROR_NOREAD: assert property (reg_rd && mir_hit |=> reg_rdata_q == 16'h0000)
    else $error("mirror read returned data");
  AST_EMUL_ALL: assert property (emul_mode |=> periph_enable_q == 12'hFFF &&
                                 route_tgt_q == periph_enable_pkg::TGT_EMUL)
    else $error("emulation did not force enables");
  AST_PINS: assert property (##1 gpio_release_q == ~periph_enable_q)
    else $error("pin release disagrees with enables");
  AST_RAM_S: assert property (!emul_mode && in_rng(a, periph_enable_pkg::RAM_S_LO,
                              periph_enable_pkg::RAM_S_HI) && !en[2] |=>
                              route_tgt_q == periph_enable_pkg::TGT_EXTERNAL)
    else $error("small RAM range not sent external");
  AST_FLASH: assert property (!emul_mode && in_rng(a, periph_enable_pkg::FLASH_LO,
                              periph_enable_pkg::FLASH_HI) && !en[5] && en[3] |=>
                              route_tgt_q == periph_enable_pkg::TGT_UNCLAIM)
    else $error("flash range misrouted with large RAM on");
  AST_WINDOW_OFF: assert property (!emul_mode && in_rng(a, periph_enable_pkg::WIN_LO,
                                   periph_enable_pkg::WIN_HI) && en == 12'h000 |=>
                                   route_tgt_q == periph_enable_pkg::TGT_EXTERNAL)
    else $error("peripheral window not external when all off");
  AST_SEG8: assert property (!emul_mode && in_rng(a, periph_enable_pkg::SEG8_LO,
                             periph_enable_pkg::SEG8_HI) && !internal_rom_enable &&
                             global_bus_enable && control_q[3] |=>
                             route_tgt_q == periph_enable_pkg::TGT_RESERVED)
    else $error("segment 8 reserved case missed");
  AST_OSC: assert property (powerdown_mode && !en[4] |=> osc_off_q)
    else $error("oscillator not stopped in power-down");
  AST_RANGE_L: assert property (!emul_mode && in_rng(a, periph_enable_pkg::RAM_L_LO,
                                periph_enable_pkg::RAM_L_HI) && en[3] |=>
                                route_tgt_q == periph_enable_pkg::TGT_RAM_L)
    else $error("large RAM not selected");

  COV_LOCK_WRITE: cover property (global_bus_enable && reg_wr && ctl_hit);
  COV_MIRROR: cover property (reg_wr && mir_hit ##1 reg_rd && ctl_hit);
  COV_RTC: cover property (route_tgt_q == periph_enable_pkg::TGT_RTC);
  COV_CAN: cover property (route_tgt_q == periph_enable_pkg::TGT_CAN ##1
                           route_tgt_q == periph_enable_pkg::TGT_EXTERNAL);

endmodule

// file: logic/periph_enable_pkg.sv
// Constants for the peripheral enable and address steering block.
// Assumes a 16-bit special register port and a 24-bit CPU address.
//
// Functional notes
// - Extension flash answers when enabled; else external only if large RAM off.
// - Clock-calendar range external only if all other peripheral enables off.
// - Large RAM answers when enabled; else external only if extension flash off.
// - Small RAM answers when enabled; otherwise its range always goes external.
// - Second CAN off frees its pins; CAN range external only if all off.
// - First CAN off frees its pins; CAN range external only if all off.
// - All peripherals off sends the whole peripheral window to external memory.
// - Pins of any disabled peripheral are released as general-purpose I/O.
// - Reset enables only the first CAN and the small RAM.
// - After global bus enable, enable register ignores writes and holds; here writes are blocked only while global_bus_enable stays high.
// - Emulation mode forces every enable set; emulation chip steers accesses.
// - Calendar off stops oscillator in power-down; else select bit decides.
// - Segment 8 picks flash sector, external memory, or reserved by enables.
// - Write-only mirror of the enable register sits at the mirror address.
// - Mirror bits 0 to 11 match enable bits; bits 12 to 15 unused.

package periph_enable_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [15:0] ADDR_CONTROL    = 16'hF024;
  localparam logic [15:0] ADDR_MIRROR     = 16'hEB7E;
  localparam logic [15:0] CONTROL_RESET   = 16'h0005;
  localparam logic [15:0] CONTROL_MASK    = 16'h0FFF;
  localparam logic [15:0] MIRROR_MASK     = 16'h0FFF;
  localparam int          EN_W            = 12;

  // ------------------------------------------------------------------
  // Enable bit positions
  // ------------------------------------------------------------------
  localparam int BIT_CAN1   = 0;
  localparam int BIT_CAN2   = 1;
  localparam int BIT_RAM_S  = 2;
  localparam int BIT_RAM_L  = 3;
  localparam int BIT_RTC    = 4;
  localparam int BIT_FLASH  = 5;
  localparam int BIT_PWM    = 6;
  localparam int BIT_ASC    = 7;
  localparam int BIT_SSC    = 8;
  localparam int BIT_I2C    = 9;
  localparam int BIT_MISC   = 10;
  localparam int BIT_PORT   = 11;
  // Bus peripherals sharing the E800..EFFF window
  localparam logic [11:0] WINDOW_PERIPH_MASK = 12'hFD3;

  // ------------------------------------------------------------------
  // Address ranges
  // ------------------------------------------------------------------
  localparam logic [23:0] SEG8_LO   = 24'h08_0000;
  localparam logic [23:0] SEG8_HI   = 24'h08_FFFF;
  localparam logic [23:0] FLASH_LO  = 24'h09_0000;
  localparam logic [23:0] FLASH_HI  = 24'h0E_FFFF;
  localparam logic [23:0] RAM_L_LO  = 24'h0F_0000;
  localparam logic [23:0] RAM_L_HI  = 24'h0F_FFFF;
  localparam logic [23:0] RAM_S_LO  = 24'h00_E000;
  localparam logic [23:0] RAM_S_HI  = 24'h00_E7FF;
  localparam logic [23:0] WIN_LO    = 24'h00_E800;
  localparam logic [23:0] WIN_HI    = 24'h00_EFFF;
  localparam logic [23:0] SSC_LO    = 24'h00_E800;
  localparam logic [23:0] ASC_LO    = 24'h00_E900;
  localparam logic [23:0] I2C_LO    = 24'h00_EA00;
  localparam logic [23:0] MISC_LO   = 24'h00_EB00;
  localparam logic [23:0] PORT_LO   = 24'h00_EB80;
  localparam logic [23:0] CAN_LO    = 24'h00_EC00;
  localparam logic [23:0] PWM_LO    = 24'h00_EC00;
  localparam logic [23:0] RTC_LO    = 24'h00_ED00;
  localparam logic [23:0] RTC_HI    = 24'h00_EDFF;
  localparam logic [23:0] SUB_256   = 24'h00_00FF;
  localparam logic [23:0] SUB_128   = 24'h00_007F;

  // ------------------------------------------------------------------
  // Routing targets
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    TGT_OTHER    = 4'h0,
    TGT_EXTERNAL = 4'h1,
    TGT_XFLASH   = 4'h3,
    TGT_RAM_L    = 4'h2,
    TGT_RAM_S    = 4'h6,
    TGT_CAN      = 4'h7,
    TGT_RTC      = 4'h5,
    TGT_XPERIPH  = 4'h4,
    TGT_IFLASH   = 4'hC,
    TGT_RESERVED = 4'hD,
    TGT_UNCLAIM  = 4'hF,
    TGT_EMUL     = 4'hE
  } target_t;

endpackage

// file: tb/cpu_model.sv
// CPU side model: drives the special register port of the enable block.
// Assumes the block answers a read exactly one cycle after the strobe.

`timescale 1ns/10ps

module cpu_model (
  input  wire logic        ref_clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_addr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata_q,
  input  wire logic        reg_rvalid_q
);
  // ------------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------------
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
  end

  // Idle lines show the inverse so a stale value never decodes again
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = (reg_rvalid_q === 1'b1) ? reg_rdata_q : 16'hxxxx;
  endtask

  task automatic wr_ctl(input logic [11:0] c);
    wr(periph_enable_pkg::ADDR_CONTROL, {4'h0, c});
  endtask

  // Called only once both configuration registers hold final values
  task automatic copy(input logic g, input logic [11:0] c);
    if (g && ((c & 12'h7D3) != 12'h000)) begin
      wr(periph_enable_pkg::ADDR_MIRROR, {4'h0, c});
    end
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the peripheral enable and steering block.
// Assumes cpu_model drives the register port; all else driven here.

`timescale 1ns/10ps

module testbench;
  logic                       ref_clk, rst_b, reg_wr, reg_rd, reg_rvalid_q;
  logic                       global_bus_enable, internal_rom_enable, emul_mode;
  logic                       powerdown_mode, osc_powerdown_select, acc_valid;
  logic                       route_valid_q, osc_off_q;
  logic [15:0]                reg_addr, reg_wdata, reg_rdata_q, mirror_q, d;
  logic [23:0]                acc_addr;
  logic [11:0]                periph_enable_q, gpio_release_q, ctl, e;
  periph_enable_pkg::target_t route_tgt_q;
  int                         failures, tests_run, cycles, i, k;
  logic [23:0] lo [9] = '{24'h08_0000, 24'h09_0000, 24'h0F_0000, 24'h00_E000, 24'h00_E800,
                          24'h00_EB00, 24'h00_EC00, 24'h00_ED00, 24'h10_0000};
  logic [23:0] sp [9] = '{24'h00_FFFF, 24'h05_FFFF, 24'h00_FFFF, 24'h00_07FF, 24'h00_07FF,
                          24'h00_00FF, 24'h00_03FF, 24'h00_00FF, 24'h00_FFFF};

  periph_enable_decode dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .global_bus_enable(global_bus_enable),
    .internal_rom_enable(internal_rom_enable), .emul_mode(emul_mode),
    .powerdown_mode(powerdown_mode), .osc_powerdown_select(osc_powerdown_select),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .route_tgt_q(route_tgt_q),
    .route_valid_q(route_valid_q), .periph_enable_q(periph_enable_q),
    .gpio_release_q(gpio_release_q), .mirror_q(mirror_q), .osc_off_q(osc_off_q));

  cpu_model cpu (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q));

  // ------------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Window slices resolved in the same order as the steering priority
  function automatic logic [3:0] exp_tgt(input logic [23:0] a, input logic [11:0] n);
    logic s;
    if (emul_mode) return periph_enable_pkg::TGT_EMUL;
    if (a inside {[24'h08_0000:24'h08_FFFF]}) begin
      if (internal_rom_enable) return periph_enable_pkg::TGT_IFLASH;
      if (!global_bus_enable || !(ctl[3] | ctl[5])) return periph_enable_pkg::TGT_EXTERNAL;
      return periph_enable_pkg::TGT_RESERVED;
    end
    if (a inside {[24'h09_0000:24'h0E_FFFF]})
      return n[5] ? periph_enable_pkg::TGT_XFLASH :
             n[3] ? periph_enable_pkg::TGT_UNCLAIM : periph_enable_pkg::TGT_EXTERNAL;
    if (a inside {[24'h0F_0000:24'h0F_FFFF]})
      return n[3] ? periph_enable_pkg::TGT_RAM_L :
             n[5] ? periph_enable_pkg::TGT_UNCLAIM : periph_enable_pkg::TGT_EXTERNAL;
    if (a inside {[24'h00_E000:24'h00_E7FF]})
      return n[2] ? periph_enable_pkg::TGT_RAM_S : periph_enable_pkg::TGT_EXTERNAL;
    if (!(a inside {[24'h00_E800:24'h00_EFFF]})) return periph_enable_pkg::TGT_OTHER;
    if (n[4] && a[11:8] == 4'hD) return periph_enable_pkg::TGT_RTC;
    s = (a[11:8] == 4'h8) ? n[8] : (a[11:8] == 4'h9) ? n[7] : (a[11:8] == 4'hA) ? n[9] :
        (a[11:8] == 4'hB) ? (a[7] ? n[11] : n[10]) : (a[11:8] == 4'hC) ? n[6] : 1'b0;
    if (s) return periph_enable_pkg::TGT_XPERIPH;
    if (a[11:10] == 2'b11 && (n[0] | n[1])) return periph_enable_pkg::TGT_CAN;
    return ((n & 12'hFD3) != 12'h000) ? periph_enable_pkg::TGT_UNCLAIM :
           periph_enable_pkg::TGT_EXTERNAL;
  endfunction

  // ------------------------------------------------------------------
  // Clock, reset and hang guard
  // ------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {rst_b, global_bus_enable, internal_rom_enable, emul_mode} = 4'h0;
    {powerdown_mode, osc_powerdown_select, acc_valid} = 3'h0;
    acc_addr = 24'h00_0000;
    void'($urandom(32'h98f460c3));
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    cpu.rd(periph_enable_pkg::ADDR_CONTROL, d);
    chk(d, 16'h0005, "reset control");
    global_bus_enable = 1'b1;
    @(negedge ref_clk);
    chk({4'h0, periph_enable_q}, 16'h0005, "reset enables");
    chk({4'h0, gpio_release_q}, 16'h0FFA, "reset gpio");
    $display("test reset done");
    global_bus_enable = 1'b0;
    cpu.wr_ctl(12'h013);
    cpu.rd(periph_enable_pkg::ADDR_CONTROL, d);
    chk(d, 16'h0013, "back to back");
    cpu.wr(periph_enable_pkg::ADDR_MIRROR, 16'hF5A5);
    chk(mirror_q, 16'h05A5, "mirror bits");
    cpu.rd(periph_enable_pkg::ADDR_MIRROR, d);
    chk(d, 16'h0000, "mirror read");
    cpu.rd(16'h1234, d);
    chk(d, 16'h0000, "unmapped read");
    $display("test registers done");
    // Random configurations, corners first: all off, then all on
    for (i = 0; i < 150; i++) begin
      global_bus_enable = 1'b0;
      ctl = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom);
      cpu.wr_ctl(ctl);
      global_bus_enable = (i < 2) ? 1'b1 : 1'($urandom);
      emul_mode = (i > 1) && ($urandom % 8 == 0);
      internal_rom_enable = 1'($urandom);
      powerdown_mode = 1'($urandom);
      osc_powerdown_select = 1'($urandom);
      if (global_bus_enable) begin
        cpu.copy(1'b1, ctl);
        if ((ctl & 12'h7D3) != 12'h000) chk(mirror_q, {4'h0, ctl}, "mirror copy");
        cpu.wr_ctl(~ctl);
        cpu.rd(periph_enable_pkg::ADDR_CONTROL, d);
        chk(d, {4'h0, ctl}, "locked control");
      end
      e = emul_mode ? 12'hFFF : (global_bus_enable ? ctl : 12'h000);
      repeat (8) begin
        k = $urandom % 9;
        // Range ends drawn often: decode bounds are where slips hide
        acc_addr = lo[k] + (($urandom % 4 == 0) ? sp[k] : ($urandom % 4 == 0) ? 24'h00_0000 :
                            24'($urandom) % (sp[k] + 1));
        acc_valid = 1'($urandom);
        @(negedge ref_clk);
        chk({12'h0, route_tgt_q}, {12'h0, exp_tgt(acc_addr, e)}, "route");
        chk({15'h0, route_valid_q}, {15'h0, acc_valid}, "route valid");
        chk({4'h0, periph_enable_q}, {4'h0, e}, "enables");
        chk({4'h0, gpio_release_q}, {4'h0, ~e}, "gpio");
        chk({15'h0, osc_off_q}, {15'h0, powerdown_mode & (~e[4] | osc_powerdown_select)},
            "osc off");
      end
    end
    $display("test random steering done");
    results();
  end
endmodule
